// *** bench/atc_adc_model.sv ***
// ADC result path model: one-cycle result strobes.
// Assumes the caller runs in the bench clock domain.
`timescale 1ns/1ps
`default_nettype none
module atc_adc_model (
  input  wire logic            ref_clk,
  output logic                 adc_valid,
  output atc_pkg::atc_src_e    adc_src,
  output atc_pkg::atc_level_t  adc_data
);
  import atc_pkg::*;
  initial begin
    adc_valid = 1'b0;
    adc_src = ATC_SRC_USB;
    adc_data = 12'h000;
  end
  task automatic send(input atc_src_e s, input atc_level_t d);
    @(posedge ref_clk);
    adc_src <= s;
    adc_data <= d;
    adc_valid <= 1'b1;
    @(posedge ref_clk);
    adc_valid <= 1'b0;
    // Stale lines after the strobe
    adc_data <= ~d;
    adc_src <= atc_src_e'(~s);
  endtask
endmodule // atc_adc_model
`default_nettype wire

// *** bench/atc_top_chk.sv ***
// Port checker of the threshold comparator block.
// Assumes one APB wait state and registered outputs.
`timescale 1ns/1ps
`default_nettype none
module atc_chk (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        adc_valid,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  AST_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_RDY: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completion");
  AST_ALIGN: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("unaligned access not refused");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  AST_RST: assert property ($fell(sys_rst) |-> !irq && !pready && !pslverr)
    else $error("outputs not cleared by reset");
  AST_IRQ_UP: assert property ($rose(irq) |-> $past(adc_valid, 3) ||
    ($past(pready, 2) && $past(pwrite, 2))) else $error("irq rose without cause");
  AST_IRQ_DN: assert property ($fell(irq) |-> $past(pready, 2) && $past(pwrite, 2))
    else $error("irq fell without a write");
endmodule // atc_chk
bind atc_top atc_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .adc_valid(adc_valid), .irq(irq));
`default_nettype wire

// *** bench/atc_top_tb.sv ***
// Self-checking bench of the threshold comparator block.
// Assumes the design package, map header and ADC model.
`timescale 1ns/1ps
`default_nettype none
`include "atc_map.svh"
module atc_top_tb;
  import atc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready, pslverr, adc_valid, irq, err, dr;
  atc_src_e    adc_src;
  atc_level_t  adc_data, l, d;
  logic [15:0] lf = 16'h0017;
  logic [15:0] r;
  logic [2:0]  c;
  logic [1:0]  u;
  logic [2:0]  cs [4];
  logic        cd [4];
  atc_level_t  cl [4];
  logic [3:0]  h = 4'h0;
  logic [3:0]  sts = 4'h0;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  atc_top u_atc_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_valid(adc_valid), .adc_src(adc_src), .adc_data(adc_data),
    .irq(irq));
  atc_adc_model u_adc (.ref_clk(ref_clk), .adc_valid(adc_valid), .adc_src(adc_src),
    .adc_data(adc_data));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic atc_src_e esrc(input logic [1:0] v, input logic [2:0] k);
    return (k == 3'h0) ? atc_src_e'({2'h0, v}) : atc_src_e'({1'b0, k} + 4'h3);
  endfunction
  // Strict threshold test: above when dir set, below otherwise
  function automatic logic exp_hit(input logic above, input atc_level_t dv,
                                   input atc_level_t lim);
    return above ? (dv > lim) : (dv < lim);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] v);
    apb(1'b1, {i, 2'h0}, v);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'h0}, 32'h0);
    chk(rdat, e);
    chk({31'h0, err}, 32'h0);
  endtask
  task automatic ev(input atc_src_e s, input atc_level_t dv);
    u_adc.send(s, dv);
    for (int v = 0; v < 4; v++) begin
      if (esrc(2'(v), cs[v]) == s) begin
        h[v] = exp_hit(cd[v], dv, cl[v]);
        sts[v] = sts[v] | h[v];
      end
    end
  endtask
  task automatic results();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 6000) begin
      fails++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    for (int k = 0; k < 4; k++) begin
      cs[k] = 3'h0;
      cd[k] = 1'b0;
      cl[k] = 12'h0;
    end
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 11; k++) rd(`ATC_IDX_CTRL + 16'(k), 32'h0);
    wr(`ATC_IDX_CTRL, 32'h0000_0F0F);
    rd(`ATC_IDX_CTRL, 32'h0000_000F);
    apb(1'b1, {`ATC_IDX_CTRL, 2'h2}, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, {16'h4040, 2'h0}, 32'h0);
    chk({31'h0, err}, 32'h1);
    rd(`ATC_IDX_CTRL, 32'h0000_000F);
    wr(`ATC_IDX_IRQ_MASK, 32'hF);
    for (int n = 0; n < 64; n++) begin
      r = rnd();
      u = r[1:0];
      c = r[4:2];
      dr = r[5];
      l = 12'(rnd());
      d = (r[7:6] == 2'h0) ? l : 12'(rnd());
      wr(`ATC_IDX_CFG1 + 16'(u), {16'h0, c, dr, l});
      cs[u] = c;
      cd[u] = dr;
      cl[u] = l;
      ev(esrc(u, c), d);
      rd(`ATC_IDX_CTRL, {20'h0, h, 8'h0F});
      rd(`ATC_IDX_SAMPLE1 + 16'(u), {20'h0, d});
    end
    rd(`ATC_IDX_IRQ_STS, {28'h0, sts});
    chk({31'h0, irq}, {31'h0, |sts});
    wr(`ATC_IDX_IRQ_MASK, 32'h0);
    wr(`ATC_IDX_IRQ_STS, 32'hF);
    rd(`ATC_IDX_IRQ_STS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`ATC_IDX_CTRL, 32'h0);
    wr(`ATC_IDX_CFG1, 32'h0000_1000);
    u_adc.send(ATC_SRC_USB, 12'hFFF);
    rd(`ATC_IDX_CTRL, 32'h0);
    rd(`ATC_IDX_IRQ_STS, 32'h0);
    wr(`ATC_IDX_CTRL, 32'h1);
    u_adc.send(ATC_SRC_USB, 12'hFFF);
    rd(`ATC_IDX_CTRL, 32'h0000_0101);
    rd(`ATC_IDX_IRQ_STS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`ATC_IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`ATC_IDX_IRQ_STS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    // Mid-run reset with live configuration
    wr(`ATC_IDX_CFG4, 32'h0000_FFFF);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 11; k++) rd(`ATC_IDX_CTRL + 16'(k), 32'h0);
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule // atc_top_tb
`default_nettype wire

// *** design/atc_map.svh ***
// Register indexes, field positions and reset values of the threshold comparators.
// Assumes byte address = 4 x index on a 32-bit APB bus.
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

`define ATC_IDX_CTRL      16'h4030
`define ATC_IDX_CFG1      16'h4031
`define ATC_IDX_CFG2      16'h4032
`define ATC_IDX_CFG3      16'h4033
`define ATC_IDX_CFG4      16'h4034
`define ATC_IDX_IRQ_STS   16'h4035
`define ATC_IDX_IRQ_MASK  16'h4036
`define ATC_IDX_SAMPLE1   16'h4037
`define ATC_IDX_SAMPLE4   16'h403A

`define ATC_CTRL_ON_LSB   0
`define ATC_CTRL_HIT_LSB  8
`define ATC_CFG_SEL_MSB   15
`define ATC_CFG_SEL_LSB   13
`define ATC_CFG_DIR_BIT   12
`define ATC_CFG_LIM_MSB   11

`define ATC_RST_REG16     16'h0000
`define ATC_RST_NIB       4'h0
`define ATC_RST_WORD      32'h0000_0000

`endif

// *** design/atc_pkg.sv ***
// Types and shared helper functions of the threshold comparators.
// Assumes the ADC result path tags each result with an atc_src_e code.
`default_nettype none

package atc_pkg;

  typedef enum logic [3:0] {
    ATC_SRC_USB,
    ATC_SRC_WALL,
    ATC_SRC_BATT,
    ATC_SRC_BACKUP,
    ATC_SRC_AIN1,
    ATC_SRC_AIN2,
    ATC_SRC_AIN3,
    ATC_SRC_AIN4,
    ATC_SRC_CHIP_TEMP,
    ATC_SRC_BATT_TEMP,
    ATC_SRC_SYS
  } atc_src_e;

  typedef enum logic [1:0] {
    ATC_BUS_IDLE,
    ATC_BUS_RESP
  } atc_bus_e;

  typedef logic [11:0] atc_level_t;

  // Source selector code of a unit to the ADC source it watches
  function automatic atc_src_e atc_sel_to_src(input logic [1:0] unit, input logic [2:0] sel);
    atc_src_e src;
    src = ATC_SRC_SYS;
    case (sel)
      3'h0: begin
        case (unit)
          2'h0:    src = ATC_SRC_USB;
          2'h1:    src = ATC_SRC_WALL;
          2'h2:    src = ATC_SRC_BATT;
          default: src = ATC_SRC_BACKUP;
        endcase
      end
      3'h1:    src = ATC_SRC_AIN1;
      3'h2:    src = ATC_SRC_AIN2;
      3'h3:    src = ATC_SRC_AIN3;
      3'h4:    src = ATC_SRC_AIN4;
      3'h5:    src = ATC_SRC_CHIP_TEMP;
      3'h6:    src = ATC_SRC_BATT_TEMP;
      default: src = ATC_SRC_SYS;
    endcase
    return src;
  endfunction

  // Threshold condition: above when dir set, below otherwise
  function automatic logic atc_crossed(input logic above, input atc_level_t data,
                                       input atc_level_t limit);
    return above ? (data > limit) : (data < limit);
  endfunction

endpackage

`default_nettype wire

// *** design/atc_top.sv ***
// Four ADC threshold comparators with APB register access and interrupt.
// Assumes APB3 master on ref_clk and ADC results as one-cycle strobes.
//
// Function
// - read-only hit flags, control bits 11:8
// - direction bit picks above or below trigger
// - read-write enables, control bits 3:0
// - selector bits 15:13; unit1 code 0 USB
// - codes 1-7: inputs 1-4, temps, system supply
// - unit2 code 0 selects wall supply
// - unit3 code 0 selects main battery
// - bit 12: 0 below, 1 above
// - bits 11:0 unsigned 12-bit threshold
// - all fields reset to zero
// - unit4 code 0 selects backup battery
// - unit4 has its own configuration register
`timescale 1ns/1ps
`default_nettype none

`include "atc_map.svh"

module atc_top #(
  parameter int UNITS = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [17:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             adc_valid,
  input  wire atc_pkg::atc_src_e adc_src,
  input  wire atc_pkg::atc_level_t adc_data,
  output logic                  irq
);
  import atc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0]      cfg [UNITS];
  logic [UNITS-1:0] on_bits;
  logic [UNITS-1:0] hit_flag;
  logic [UNITS-1:0] hit_event;
  logic [UNITS-1:0] irq_sts;
  logic [UNITS-1:0] irq_mask;
  atc_level_t       last_sample [UNITS];
  atc_bus_e         bus_state;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [15:0] reg_idx;
  logic        aligned;
  logic        mapped;
  logic        done;
  logic        wr_done;

  assign reg_idx = paddr[17:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped  = aligned && (reg_idx >= `ATC_IDX_CTRL) && (reg_idx <= `ATC_IDX_SAMPLE4);
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite && mapped;

  function automatic logic is_cfg(input logic [15:0] idx, input int u);
    return idx == (`ATC_IDX_CFG1 + 16'(u));
  endfunction

  function automatic logic [31:0] read_word(input logic [15:0] idx);
    logic [31:0] w;
    w = `ATC_RST_WORD;
    case (idx)
      `ATC_IDX_CTRL: begin
        w[`ATC_CTRL_HIT_LSB +: 4] = hit_flag;
        w[`ATC_CTRL_ON_LSB +: 4]  = on_bits;
      end
      `ATC_IDX_CFG1:     w[15:0] = cfg[0];
      `ATC_IDX_CFG2:     w[15:0] = cfg[1];
      `ATC_IDX_CFG3:     w[15:0] = cfg[2];
      `ATC_IDX_CFG4:     w[15:0] = cfg[3];
      `ATC_IDX_IRQ_STS:  w[3:0]  = irq_sts;
      `ATC_IDX_IRQ_MASK: w[3:0]  = irq_mask;
      default: begin
        if (idx >= `ATC_IDX_SAMPLE1 && idx <= `ATC_IDX_SAMPLE4) begin
          w[11:0] = last_sample[2'(idx - `ATC_IDX_SAMPLE1)];
        end
      end
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_state <= ATC_BUS_IDLE;
      pready    <= 1'b0;
    end else begin
      case (bus_state)
        ATC_BUS_IDLE: begin
          if (psel && penable) begin
            bus_state <= ATC_BUS_RESP;
            pready    <= 1'b1;
          end
        end
        ATC_BUS_RESP: begin
          bus_state <= ATC_BUS_IDLE;
          pready    <= 1'b0;
        end
        default: begin
          bus_state <= ATC_BUS_IDLE;
          pready    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata  <= `ATC_RST_WORD;
      pslverr <= 1'b0;
    end else if (bus_state == ATC_BUS_IDLE && psel && penable) begin
      prdata  <= (!pwrite && mapped) ? read_word(reg_idx) : `ATC_RST_WORD;
      pslverr <= !mapped;
    end else if (bus_state == ATC_BUS_RESP) begin
      prdata  <= `ATC_RST_WORD;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      on_bits <= `ATC_RST_NIB;
    end else if (wr_done && reg_idx == `ATC_IDX_CTRL) begin
      on_bits <= pwdata[`ATC_CTRL_ON_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int u = 0; u < UNITS; u++) begin
        cfg[u] <= `ATC_RST_REG16;
      end
    end else if (wr_done) begin
      for (int u = 0; u < UNITS; u++) begin
        if (is_cfg(reg_idx, u)) begin
          cfg[u] <= pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_mask <= `ATC_RST_NIB;
    end else if (wr_done && reg_idx == `ATC_IDX_IRQ_MASK) begin
      irq_mask <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear, set wins
  logic [UNITS-1:0] sts_clr;

  assign sts_clr = (wr_done && reg_idx == `ATC_IDX_IRQ_STS) ? pwdata[3:0] : `ATC_RST_NIB;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_sts <= `ATC_RST_NIB;
    end else begin
      irq_sts <= (irq_sts & ~sts_clr) | hit_event;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator units
  for (genvar g = 0; g < UNITS; g++) begin : g_unit
    atc_unit #(
      .UNIT (2'(g))
    ) u_unit (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .on          (on_bits[g]),
      .input_sel   (cfg[g][`ATC_CFG_SEL_MSB:`ATC_CFG_SEL_LSB]),
      .above_dir   (cfg[g][`ATC_CFG_DIR_BIT]),
      .limit       (cfg[g][`ATC_CFG_LIM_MSB:0]),
      .adc_valid   (adc_valid),
      .adc_src     (adc_src),
      .adc_data    (adc_data),
      .hit_flag    (hit_flag[g]),
      .hit_event   (hit_event[g]),
      .last_sample (last_sample[g])
    );
  end

endmodule // atc_top

`default_nettype wire

// *** design/atc_unit.sv ***
// One threshold comparator: evaluates each matching ADC result.
// Assumes adc_valid is a one-cycle strobe with adc_src and adc_data valid.
`timescale 1ns/1ps
`default_nettype none

module atc_unit #(
  parameter logic [1:0] UNIT = 2'h0
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             on,
  input  wire logic [2:0]       input_sel,
  input  wire logic             above_dir,
  input  wire atc_pkg::atc_level_t limit,
  input  wire logic             adc_valid,
  input  wire atc_pkg::atc_src_e adc_src,
  input  wire atc_pkg::atc_level_t adc_data,
  output logic                  hit_flag,
  output logic                  hit_event,
  output atc_pkg::atc_level_t   last_sample
);
  import atc_pkg::*;

  logic take;

  assign take = on && adc_valid && (adc_src == atc_sel_to_src(UNIT, input_sel));

  ////////////////////////////////////////////////////////////////////////////
  // Status flag follows the latest evaluation, cleared while disabled
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hit_flag <= 1'b0;
    end else if (!on) begin
      hit_flag <= 1'b0;
    end else if (take) begin
      hit_flag <= atc_crossed(above_dir, adc_data, limit);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hit_event <= 1'b0;
    end else begin
      hit_event <= take && atc_crossed(above_dir, adc_data, limit);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      last_sample <= 12'h000;
    end else if (take) begin
      last_sample <= adc_data;
    end
  end

endmodule // atc_unit

`default_nettype wire
